// *** pkg/cies_pkg.sv ***
// constants and types for the instruction execute subset
package cies_pkg;
   localparam int DATA_W          = 8;
   localparam int FADDR_W         = 7;
   localparam int PC_W            = 13;
   localparam int STACK_DEPTH     = 8;
   localparam int WDT_W           = 8;
   localparam int PRESC_W         = 8;
   localparam logic [7:0] WDT_CLEAR_VAL   = 8'h00;
   localparam logic [7:0] PRESC_CLEAR_VAL = 8'h00;
   localparam int RETURN_CYCLES   = 2;
   // status flag reset values and destination select codes
   localparam logic PWRDN_RESET_VAL = 1'b1;
   localparam logic WDEXP_RESET_VAL = 1'b1;
   localparam logic C_RESET_VAL   = 1'b0;
   localparam logic DC_RESET_VAL  = 1'b0;
   localparam logic Z_RESET_VAL   = 1'b0;
   localparam logic DEST_ACC      = 1'b0;
   localparam logic DEST_FILE     = 1'b1;
   // operation codes presented by the decode stage
   typedef enum logic [3:0] {
      CIES_OP_NONE,
      CIES_OP_POWER_DOWN,
      CIES_OP_RETURN,
      CIES_OP_SUB_ACC_FROM_LITERAL,
      CIES_OP_ROTATE_RIGHT_VIA_CARRY,
      CIES_OP_SUB_ACC_FROM_FILE,
      CIES_OP_NIBBLE_EXCHANGE,
      CIES_OP_XOR_LITERAL_INTO_ACC,
      CIES_OP_XOR_ACC_WITH_FILE
   } cies_op_t;
endpackage

// *** logic/cies_stack.sv ***
// hardware return stack with registered top entry
`timescale 1ns/1ps
module cies_stack #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic             i_push,
   input  wire logic [WIDTH-1:0] i_push_data,
   input  wire logic             i_pop,
   output logic      [WIDTH-1:0] o_top
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    ptr_reg;
   wire  [PW-1:0]    top_idx = ptr_reg - 1'b1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("stack depth must be a power of two");
   end

   // circular pointer: wraps silently on overflow and on underflow
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ptr_reg <= '0;
      end else if (i_push) begin
         ptr_reg <= ptr_reg + 1'b1;
      end else if (i_pop) begin
         ptr_reg <= top_idx;
      end
   end

   // entry storage, no reset needed
   always_ff @(posedge i_mclk) begin
      if (i_push) begin
         mem[ptr_reg] <= i_push_data;
      end
   end

   // top entry captured on the pop edge and held, so it still stands when the load pulse comes
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_top <= '0;
      end else if (i_pop) begin
         o_top <= mem[top_idx];
      end
   end
endmodule

// *** logic/cies_core.sv ***
// execute stage for power-down, return, subtract, rotate, swap and xor operations
// Functional notes
// RULE_01 - power-down clears power-down flag, sets watchdog-expiry flag, leaves others alone
// RULE_02 - power-down clears watchdog counter and its prescaler
// RULE_03 - power-down halts the core after flag and watchdog update
// RULE_04 - while halted the oscillator enable is low
// RULE_05 - return pops stack into program counter, no flags, two cycles
// RULE_06 - literal minus accumulator into accumulator, updates carry, nibble-carry, zero
// RULE_07 - rotate right through carry, only carry flag changes
// RULE_08 - file minus accumulator to chosen destination, updates carry, nibble-carry, zero
// RULE_09 - nibble exchange to chosen destination, no flags change
// RULE_10 - literal xor accumulator into accumulator, zero flag only
// RULE_11 - file xor accumulator to chosen destination, zero flag only
// RULE_12 - destination bit 0 selects accumulator, 1 selects file register
// RULE_13 - file address is 7 bits, literal is 8 bits
// RULE_14 - zero on zero result; subtraction carries mean no borrow
`timescale 1ns/1ps
module cies_core
   import cies_pkg::*;
#(
   parameter int STACK_DEPTH_P = cies_pkg::STACK_DEPTH
) (
   input  wire logic                          i_mclk,
   input  wire logic                          i_rst,
   input  wire logic                          i_valid,
   input  wire cies_pkg::cies_op_t            i_op,
   input  wire logic [cies_pkg::FADDR_W-1:0]  i_faddr,
   input  wire logic                          i_dest,
   input  wire logic [cies_pkg::DATA_W-1:0]   i_literal,
   input  wire logic [cies_pkg::DATA_W-1:0]   i_file_rdata,
   input  wire logic                          i_call,
   input  wire logic [cies_pkg::PC_W-1:0]     i_call_ret_pc,
   input  wire logic                          i_wake,
   input  wire logic                          i_wdt_tick,
   output logic                               o_ready,
   output logic [cies_pkg::FADDR_W-1:0]       o_file_addr,
   output logic                               o_file_we,
   output logic [cies_pkg::DATA_W-1:0]        o_file_wdata,
   output logic [cies_pkg::DATA_W-1:0]        o_acc,
   output logic                               o_flag_c,
   output logic                               o_flag_dc,
   output logic                               o_flag_z,
   output logic                               o_power_down_flag,
   output logic                               o_watchdog_expiry_flag,
   output logic [cies_pkg::WDT_W-1:0]         o_watchdog_counter,
   output logic [cies_pkg::PRESC_W-1:0]       o_wdt_prescaler,
   output logic                               o_pc_load,
   output logic [cies_pkg::PC_W-1:0]          o_pc_value,
   output logic                               o_halted,
   output logic                               o_osc_enable
);
   import cies_pkg::*;

   typedef enum logic [1:0] {CIES_RUN, CIES_RET_WAIT, CIES_HALT} cies_state_t;

   cies_state_t          state_reg;
   cies_state_t          state_next;
   logic [DATA_W-1:0]    acc_reg;
   logic                 c_reg;
   logic                 dc_reg;
   logic                 z_reg;
   logic                 pwrdn_reg;
   logic                 wdexp_reg;
   logic [WDT_W-1:0]     wdt_reg;
   logic [PRESC_W-1:0]   presc_reg;
   logic [FADDR_W-1:0]   faddr_reg;
   logic                 fwe_reg;
   logic [DATA_W-1:0]    fwdata_reg;
   logic                 pc_load_reg;
   logic [PC_W-1:0]      stack_top;

   initial begin
      if (STACK_DEPTH_P < 2) $error("stack depth too small");
   end

   // an operation is taken only while running
   wire run     = (state_reg == CIES_RUN);
   wire take    = run && i_valid;
   wire is_halt = take && (i_op == CIES_OP_POWER_DOWN);
   wire is_ret  = take && (i_op == CIES_OP_RETURN);
   wire is_subl = take && (i_op == CIES_OP_SUB_ACC_FROM_LITERAL);
   wire is_rrf  = take && (i_op == CIES_OP_ROTATE_RIGHT_VIA_CARRY);
   wire is_subf = take && (i_op == CIES_OP_SUB_ACC_FROM_FILE);
   wire is_swap = take && (i_op == CIES_OP_NIBBLE_EXCHANGE);
   wire is_xorl = take && (i_op == CIES_OP_XOR_LITERAL_INTO_ACC);
   wire is_xorf = take && (i_op == CIES_OP_XOR_ACC_WITH_FILE);
   wire is_file = is_rrf || is_subf || is_swap || is_xorf;
   wire is_sub  = is_subl || is_subf;

   // subtraction as a + ~acc + 1, carry out means no borrow
   wire [DATA_W-1:0] sub_a     = is_subl ? i_literal : i_file_rdata;             // see RULE_13
   wire [DATA_W:0]   sub_full  = {1'b0, sub_a} + {1'b0, ~acc_reg} + 9'h001;     // see RULE_06 see RULE_08
   wire [4:0]        sub_low   = {1'b0, sub_a[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
   wire              sub_c     = sub_full[DATA_W];                               // see RULE_14
   wire              sub_dc    = sub_low[4];                                     // see RULE_14

   // result of the file and literal operations
   wire [DATA_W-1:0] rrf_res   = {c_reg, i_file_rdata[DATA_W-1:1]};              // see RULE_07
   wire [DATA_W-1:0] swap_res  = {i_file_rdata[3:0], i_file_rdata[7:4]};         // see RULE_09
   wire [DATA_W-1:0] xorl_res  = acc_reg ^ i_literal;                            // see RULE_10
   wire [DATA_W-1:0] xorf_res  = acc_reg ^ i_file_rdata;                         // see RULE_11
   wire [DATA_W-1:0] result    = is_sub  ? sub_full[DATA_W-1:0] :
                                 is_rrf  ? rrf_res :
                                 is_swap ? swap_res :
                                 is_xorl ? xorl_res : xorf_res;
   wire              res_zero  = (result == '0);                                 // see RULE_14

   // destination select for file operands
   wire to_file = is_file && (i_dest == DEST_FILE);                              // see RULE_12
   wire to_acc  = is_subl || is_xorl || (is_file && (i_dest == DEST_ACC));       // see RULE_12

   // state sequencing: return holds one extra cycle, power-down halts until wake
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CIES_RUN: begin
            if (is_ret) begin
               state_next = CIES_RET_WAIT;                                       // see RULE_05
            end else if (is_halt) begin
               state_next = CIES_HALT;                                           // see RULE_03
            end
         end
         CIES_RET_WAIT: begin
            state_next = CIES_RUN;
         end
         CIES_HALT: begin
            if (i_wake) begin
               state_next = CIES_RUN;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= CIES_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // accumulator and arithmetic flags
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         acc_reg <= '0;
         c_reg   <= C_RESET_VAL;
         dc_reg  <= DC_RESET_VAL;
         z_reg   <= Z_RESET_VAL;
      end else begin
         if (to_acc) begin
            acc_reg <= result;                                                   // see RULE_12
         end
         if (is_sub) begin
            c_reg <= sub_c;                                                      // see RULE_06 see RULE_08
            dc_reg <= sub_dc;
         end else if (is_rrf) begin
            c_reg <= i_file_rdata[0];                                            // see RULE_07
         end
         if (is_sub || is_xorl || is_xorf) begin
            z_reg <= res_zero;                                                   // see RULE_10 see RULE_11
         end
      end
   end

   // power-down status and watchdog
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pwrdn_reg <= PWRDN_RESET_VAL;
         wdexp_reg <= WDEXP_RESET_VAL;
         wdt_reg   <= WDT_CLEAR_VAL;
         presc_reg <= PRESC_CLEAR_VAL;
      end else if (is_halt) begin
         pwrdn_reg <= 1'b0;                                                      // see RULE_01
         wdexp_reg <= 1'b1;                                                      // see RULE_01
         wdt_reg   <= WDT_CLEAR_VAL;                                             // see RULE_02
         presc_reg <= PRESC_CLEAR_VAL;                                           // see RULE_02
      end else if (i_wdt_tick) begin
         {wdt_reg, presc_reg} <= {wdt_reg, presc_reg} + 16'h0001;
      end
   end

   // file write-back and program counter load
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         faddr_reg   <= '0;
         fwe_reg     <= 1'b0;
         fwdata_reg  <= '0;
         pc_load_reg <= 1'b0;
      end else begin
         fwe_reg     <= to_file;                                                 // see RULE_12
         pc_load_reg <= (state_reg == CIES_RET_WAIT);                            // see RULE_05
         if (to_file) begin
            faddr_reg  <= i_faddr;                                               // see RULE_13
            fwdata_reg <= result;
         end
      end
   end

   // return stack, popped when the return is taken
   cies_stack #(
      .WIDTH (PC_W),
      .DEPTH (STACK_DEPTH_P)
   ) u_stack (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_push      (i_call && run),
      .i_push_data (i_call_ret_pc),
      .i_pop       (is_ret),                                                     // see RULE_05
      .o_top       (stack_top)
   );

   // outputs
   assign o_ready                = run;
   assign o_file_addr            = faddr_reg;                                    // write address stands with o_file_we, see RULE_12
   assign o_file_we              = fwe_reg;
   assign o_file_wdata           = fwdata_reg;
   assign o_acc                  = acc_reg;
   assign o_flag_c               = c_reg;
   assign o_flag_dc              = dc_reg;
   assign o_flag_z               = z_reg;
   assign o_power_down_flag      = pwrdn_reg;
   assign o_watchdog_expiry_flag = wdexp_reg;
   assign o_watchdog_counter     = wdt_reg;
   assign o_wdt_prescaler        = presc_reg;
   assign o_pc_load              = pc_load_reg;
   assign o_pc_value             = stack_top;
   assign o_halted               = (state_reg == CIES_HALT);                     // see RULE_03
   assign o_osc_enable           = (state_reg != CIES_HALT);                     // see RULE_04
endmodule

// *** testbench/cies_core_sva.sv ***
// assertion checker for the execute subset core ports
`timescale 1ns/1ps
module cies_core_sva
   import cies_pkg::*;
(
   input wire logic                  i_mclk,
   input wire logic                  i_rst,
   input wire logic                  i_valid,
   input wire cies_pkg::cies_op_t    i_op,
   input wire logic                  i_dest,
   input wire logic [DATA_W-1:0]     i_literal,
   input wire logic                  o_ready,
   input wire logic                  o_file_we,
   input wire logic [DATA_W-1:0]     o_acc,
   input wire logic                  o_flag_c,
   input wire logic                  o_flag_dc,
   input wire logic                  o_flag_z,
   input wire logic                  o_power_down_flag,
   input wire logic                  o_watchdog_expiry_flag,
   input wire logic [WDT_W-1:0]      o_watchdog_counter,
   input wire logic [PRESC_W-1:0]    o_wdt_prescaler,
   input wire logic                  o_pc_load,
   input wire logic                  o_halted,
   input wire logic                  o_osc_enable
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // operation taken this edge, and the file-operand class
   wire take = i_valid && o_ready;
   wire pdn  = take && i_op == CIES_OP_POWER_DOWN;
   wire fop  = i_op inside {CIES_OP_ROTATE_RIGHT_VIA_CARRY, CIES_OP_SUB_ACC_FROM_FILE,
                            CIES_OP_NIBBLE_EXCHANGE, CIES_OP_XOR_ACC_WITH_FILE};
   wire [2:0] flags = {o_flag_c, o_flag_dc, o_flag_z};
   // return: wait cycle, then program counter load
   sequence ret_take; take && i_op == CIES_OP_RETURN; endsequence
   sequence ret_done; !o_ready ##[1:2] o_pc_load; endsequence
   a_pd_status: assert property (pdn |=> !o_power_down_flag && o_watchdog_expiry_flag && $stable(flags))
      else $error("power-down status flags wrong");
   a_pd_wdt_clear: assert property (pdn |=> o_watchdog_counter == WDT_CLEAR_VAL && o_wdt_prescaler == PRESC_CLEAR_VAL)
      else $error("watchdog not cleared by power-down");
   a_pd_halts: assert property (pdn |=> o_halted && !o_ready)
      else $error("power-down did not halt");
   a_halt_osc_off: assert property (o_halted |-> !o_osc_enable && !o_ready)
      else $error("oscillator running while halted");
   a_ret_pop: assert property (ret_take |=> ret_done)
      else $error("return timing wrong");
   a_ret_flags: assert property (ret_take |=> $stable(flags) [*2])
      else $error("return changed flags");
   a_subl_math: assert property (take && i_op == CIES_OP_SUB_ACC_FROM_LITERAL |=>
      o_acc == 8'($past(i_literal) - $past(o_acc)) && o_flag_c == ($past(i_literal) >= $past(o_acc))
      && o_flag_z == (o_acc == 8'h00)) else $error("literal subtract wrong");
   a_xorl_zero: assert property (take && i_op == CIES_OP_XOR_LITERAL_INTO_ACC |=>
      o_acc == ($past(i_literal) ^ $past(o_acc)) && o_flag_z == (o_acc == 8'h00)
      && $stable({o_flag_c, o_flag_dc})) else $error("literal xor wrong");
   a_dest_write: assert property (take && fop |=> o_file_we == $past(i_dest))
      else $error("destination select wrong");
   a_swap_flags: assert property (take && i_op == CIES_OP_NIBBLE_EXCHANGE |=> $stable(flags))
      else $error("nibble exchange changed flags");
endmodule
bind cies_core cies_core_sva cies_core_sva_i (
   .i_mclk (i_mclk), .i_rst (i_rst), .i_valid (i_valid), .i_op (i_op), .i_dest (i_dest), .i_literal (i_literal),
   .o_ready (o_ready), .o_file_we (o_file_we), .o_acc (o_acc), .o_flag_c (o_flag_c), .o_flag_dc (o_flag_dc),
   .o_flag_z (o_flag_z), .o_power_down_flag (o_power_down_flag), .o_watchdog_expiry_flag (o_watchdog_expiry_flag),
   .o_watchdog_counter (o_watchdog_counter), .o_wdt_prescaler (o_wdt_prescaler), .o_pc_load (o_pc_load),
   .o_halted (o_halted), .o_osc_enable (o_osc_enable)
);

// *** testbench/tb_top.sv ***
// self-checking bench for the execute subset core
`timescale 1ns/1ps
module tb_top;
   import cies_pkg::*;
   typedef struct packed {logic [7:0] acc; logic c; logic dc; logic z; logic we; logic [7:0] wd;} cies_note_t;
   logic        i_mclk = 0, i_rst = 1, i_valid = 0, i_dest = 0, i_call = 0, i_wake = 0, i_wdt_tick = 0;
   cies_op_t    i_op = CIES_OP_NONE;
   logic [6:0]  i_faddr = 0, o_file_addr;
   logic [7:0]  i_literal = 0, i_file_rdata = 0, o_acc, o_file_wdata, o_watchdog_counter, o_wdt_prescaler;
   logic [12:0] i_call_ret_pc = 0, o_pc_value;
   logic        o_ready, o_file_we, o_flag_c, o_flag_dc, o_flag_z, o_power_down_flag, o_watchdog_expiry_flag;
   logic        o_pc_load, o_halted, o_osc_enable, took = 0;
   logic [7:0]  m_acc = 0;
   logic        m_c = 0, m_dc = 0, m_z = 0;
   int          mismatches = 0, n_compared = 0;
   cies_note_t  notes[$];
   logic [12:0] stk[$], pcs[$];
   logic [6:0]  fas[$];
   cies_core cies_core_i (
      .i_mclk (i_mclk), .i_rst (i_rst), .i_valid (i_valid), .i_op (i_op), .i_faddr (i_faddr), .i_dest (i_dest),
      .i_literal (i_literal), .i_file_rdata (i_file_rdata), .i_call (i_call), .i_call_ret_pc (i_call_ret_pc),
      .i_wake (i_wake), .i_wdt_tick (i_wdt_tick), .o_ready (o_ready), .o_file_addr (o_file_addr),
      .o_file_we (o_file_we), .o_file_wdata (o_file_wdata), .o_acc (o_acc), .o_flag_c (o_flag_c),
      .o_flag_dc (o_flag_dc), .o_flag_z (o_flag_z), .o_power_down_flag (o_power_down_flag),
      .o_watchdog_expiry_flag (o_watchdog_expiry_flag), .o_watchdog_counter (o_watchdog_counter),
      .o_wdt_prescaler (o_wdt_prescaler), .o_pc_load (o_pc_load), .o_pc_value (o_pc_value),
      .o_halted (o_halted), .o_osc_enable (o_osc_enable)
   );
   // clock
   initial begin
      forever #25 i_mclk = ~i_mclk;
   end
   task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_note(input cies_note_t e);
      cies_note_t g;
      g = '{o_acc, o_flag_c, o_flag_dc, o_flag_z, o_file_we, e.we ? o_file_wdata : e.wd};
      cmp_val(24'(g), 24'(e));
      if (e.we) cmp_val(24'(o_file_addr), 24'(fas.pop_front()));
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // drive one alu operation and note its expected result
   task automatic issue(input cies_op_t op, input logic [7:0] k, input logic [7:0] f, input logic d);
      logic [8:0] r;
      logic [7:0] a;
      logic       lit;
      logic [6:0] fa;
      @(posedge i_mclk);
      fa = 7'($urandom);
      i_valid <= 1'b1;
      i_op <= op;
      i_literal <= k;
      i_file_rdata <= f;
      i_dest <= d;
      i_faddr <= fa;
      lit = op inside {CIES_OP_SUB_ACC_FROM_LITERAL, CIES_OP_XOR_LITERAL_INTO_ACC};
      a = lit ? k : f;
      r = 9'h000;
      case (op)
         CIES_OP_SUB_ACC_FROM_LITERAL, CIES_OP_SUB_ACC_FROM_FILE: begin
            r = {1'b0, a} - {1'b0, m_acc};
            m_c = ~r[8];
            m_dc = a[3:0] >= m_acc[3:0];
            m_z = r[7:0] == 8'h00;
         end
         CIES_OP_ROTATE_RIGHT_VIA_CARRY: begin
            r = {1'b0, m_c, f[7:1]};
            m_c = f[0];
         end
         CIES_OP_NIBBLE_EXCHANGE: r = {1'b0, f[3:0], f[7:4]};
         default: begin
            r = {1'b0, m_acc ^ a};
            m_z = r[7:0] == 8'h00;
         end
      endcase
      if (lit || !d) m_acc = r[7:0];
      notes.push_back('{m_acc, m_c, m_dc, m_z, !lit && d, r[7:0]});
      if (!lit && d) fas.push_back(fa);
   endtask
   // notes edges where an alu operation was taken
   always @(posedge i_mclk) took <= i_valid && o_ready && i_op >= CIES_OP_SUB_ACC_FROM_LITERAL;
   // compares each visible result with the oldest note
   always @(negedge i_mclk) begin
      if (took) begin
         if (notes.size() == 0) cmp_val(24'h1, 24'h0);
         else cmp_note(notes.pop_front());
      end
      if (o_pc_load) begin
         if (pcs.size() == 0) cmp_val(24'h2, 24'h0);
         else cmp_val(24'(o_pc_value), 24'(pcs.pop_front()));
      end
   end
   // main sequence
   initial begin
      void'($urandom(44642));
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      repeat (150) issue(cies_op_t'(3 + $urandom % 6), 8'($urandom), 8'($urandom), 1'($urandom));
      issue(CIES_OP_XOR_LITERAL_INTO_ACC, m_acc, 8'h00, 1'b0);
      issue(CIES_OP_SUB_ACC_FROM_LITERAL, 8'h00, 8'h00, 1'b0);
      issue(CIES_OP_XOR_LITERAL_INTO_ACC, 8'hFF, 8'h00, 1'b0);
      issue(CIES_OP_SUB_ACC_FROM_LITERAL, 8'h00, 8'h00, 1'b0);
      for (int j = 0; j < 2; j++) begin
         @(posedge i_mclk);
         i_valid <= 1'b0;
         i_call <= 1'b1;
         stk.push_back(13'($urandom));
         i_call_ret_pc <= stk[$];
      end
      for (int j = 0; j < 2; j++) begin
         @(posedge i_mclk);
         i_call <= 1'b0;
         i_valid <= 1'b1;
         i_op <= CIES_OP_RETURN;
         pcs.push_back(stk.pop_back());
         @(posedge i_mclk);
         i_valid <= 1'b0;
         repeat (2) @(posedge i_mclk);
      end
      // 300 ticks leave both the counter and the prescaler nonzero before the power-down
      @(posedge i_mclk) i_wdt_tick <= 1'b1;
      repeat (300) @(posedge i_mclk);
      i_wdt_tick <= 1'b0;
      @(negedge i_mclk);
      cmp_val(24'({o_watchdog_counter, o_wdt_prescaler}), 24'h00012C);
      issue(CIES_OP_XOR_LITERAL_INTO_ACC, 8'h3C, 8'h00, 1'b0);
      @(posedge i_mclk);
      i_op <= CIES_OP_POWER_DOWN;
      @(posedge i_mclk);
      i_op <= CIES_OP_XOR_LITERAL_INTO_ACC;
      i_literal <= 8'h5A;
      repeat (2) @(negedge i_mclk);
      cmp_val(24'({o_power_down_flag, o_watchdog_expiry_flag, o_watchdog_counter, o_wdt_prescaler, o_halted,
                   o_osc_enable, o_ready}), 24'h080004);
      @(posedge i_mclk);
      i_valid <= 1'b0;
      i_wake <= 1'b1;
      @(posedge i_mclk) i_wake <= 1'b0;
      // ready is looked at away from the edge that changes it
      for (int t = 0; t < 8 && o_ready !== 1'b1; t++) @(negedge i_mclk);
      if (o_ready !== 1'b1) begin
         cmp_val(24'h0, 24'h1);
      end else begin
         cmp_val(24'({o_power_down_flag, o_watchdog_expiry_flag}), 24'h1);
         repeat (10) issue(cies_op_t'(3 + $urandom % 6), 8'($urandom), 8'($urandom), 1'($urandom));
         @(posedge i_mclk) i_valid <= 1'b0;
         repeat (3) @(posedge i_mclk);
         cmp_val(24'(notes.size() + pcs.size() + fas.size()), 24'h0);
      end
      final_report();
   end
endmodule
